// ===== rtl/mdc_dma_ctrl.sv
/*
 * eight-channel dma engine moving elements between peripheral
 * registers and a dual-port dma ram on its own port.
 * assumes: config inputs, requests and read data come from logic on
 * core_clk; both read ports return data one cycle after the strobe.
 */
`default_nettype none
`include "mdc_regs.svh"
// Contract
// [R1] eight independent transfer channels
// [R2] private configuration and status per channel
// [R3] ram to peripheral or peripheral to ram
// [R4] word or byte element per channel
// [R5] ram pointer, optional post-increment
// [R6] peripheral supplies low ram address bits
// [R7] one-shot stops after one block
// [R8] continuous reloads start after each block
// [R9] ping-pong alternates two start addresses
// [R10] start by peripheral or forced request
// [R11] trigger selectable among twenty peripherals
// [R12] interrupt on block completion; code raises it only while halfIrq is clear
// [R13] optional interrupt at half block
// [R14] dedicated ram port, no processor cycles
// [R15] first request select code set
// [R16] second request select code set
// [R17] software keeps buffers inside dma ram
// [R18] whole block moves without software help
// [R19] lowest channel first, one element
// [R20] block counter decrements to terminal value
module mdc_dma_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire mdc_pkg::mdc_chan_cfg_type [`MDC_NCH-1:0] chanCfg,
  input wire logic [`MDC_NCH-1:0] forceReq,
  input wire logic [`MDC_NIRQ-1:0] periphIrq,
  input wire logic [`MDC_IND_W-1:0] periphIndBits,
  input wire logic [`MDC_DW-1:0] periphRdata,
  input wire logic [`MDC_DW-1:0] ramRdata,
  output var mdc_pkg::mdc_ram_req_type ramReq,
  output var mdc_pkg::mdc_per_req_type perReq,
  output var logic [`MDC_NCH-1:0] chanIrq,
  output var logic [`MDC_NCH-1:0] chanBusy
);
  import mdc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // reset release and helpers

  logic [1:0] rstSync_r;
  logic rstN;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // [R15] [R16] accepted select codes
  function automatic logic irqKnown(input logic [`MDC_SELW-1:0] s);
    case (s)
      `MDC_IRQ_EXT0, `MDC_IRQ_CAP1, `MDC_IRQ_CMP1, `MDC_IRQ_CAP2,
      `MDC_IRQ_CMP2, `MDC_IRQ_TMR2, `MDC_IRQ_TMR3, `MDC_IRQ_SPI1,
      `MDC_IRQ_U1RX, `MDC_IRQ_U1TX, `MDC_IRQ_ADC1, `MDC_IRQ_ADC2,
      `MDC_IRQ_U2RX, `MDC_IRQ_U2TX, `MDC_IRQ_SPI2, `MDC_IRQ_CAN1RX,
      `MDC_IRQ_CAN2RX, `MDC_IRQ_CODEC, `MDC_IRQ_CAN1TX,
      `MDC_IRQ_CAN2TX: irqKnown = 1'b1;
      default: irqKnown = 1'b0;
    endcase
  endfunction

  function automatic logic [`MDC_CHW-1:0] lowestIdx(input logic [`MDC_NCH-1:0] v);
    lowestIdx = '0;
    for (int k = `MDC_NCH - 1; k >= 0; k--) begin
      if (v[k]) begin
        lowestIdx = `MDC_CHW'(k);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // per-channel request capture

  logic [`MDC_AW-1:0] ptr_r [`MDC_NCH];
  logic [`MDC_LW-1:0] remain_r [`MDC_NCH];
  logic [`MDC_NCH-1:0] pend_r, halted_r, pingB_r, enPrev_r;
  logic [`MDC_NCH-1:0] enVec, reqHit, startup, pendable;
  mdc_state_type state_r;
  logic [`MDC_CHW-1:0] cur_r;
  logic [`MDC_AW-1:0] addr_r;

  genvar g;
  generate
    for (g = 0; g < `MDC_NCH; g++) begin : gReq
      assign enVec[g] = chanCfg[g].enable;
      // [R10] [R11] peripheral or forced trigger
      assign reqHit[g] = chanCfg[g].enable && !halted_r[g] &&
        ((irqKnown(chanCfg[g].reqSel) && periphIrq[chanCfg[g].reqSel])
        || forceReq[g]);
    end
  endgenerate

  assign startup = enVec & ~enPrev_r;
  assign pendable = pend_r & enVec & ~halted_r;

  ////////////////////////////////////////////////////////////////////
  // arbitration and current-channel view

  logic grant;
  logic [`MDC_CHW-1:0] gntIdx;
  mdc_chan_cfg_type gCfg, curCfg;
  logic [`MDC_AW-1:0] gPtr, curPtr, incPtr, reloadPtr, gAddr;
  logic [`MDC_LW-1:0] curRemain;
  logic stepNow, endNow, halfNow, curPing;
  logic [`MDC_NCH-1:0] curMask;

  // [R19] lowest pending channel wins
  assign grant = (state_r == MDC_ST_IDLE) && (|pendable);
  assign gntIdx = lowestIdx(pendable);
  assign gCfg = chanCfg[gntIdx];
  assign gPtr = ptr_r[gntIdx];
  // [R6] peripheral bits replace the word offset
  assign gAddr = gCfg.periphInd ?
    {gPtr[`MDC_AW-1:`MDC_IND_W+1], periphIndBits, 1'b0} : gPtr;

  assign curCfg = chanCfg[cur_r];
  assign curPtr = ptr_r[cur_r];
  assign curRemain = remain_r[cur_r];
  assign curPing = pingB_r[cur_r];
  assign curMask = `MDC_NCH'(1) << cur_r;
  assign stepNow = (state_r == MDC_ST_CAP);
  // [R20] terminal count and midpoint
  assign endNow = (curRemain == `MDC_CNT_RST);
  assign halfNow = (curRemain == (curCfg.blockLen >> 1));
  // [R4] [R5] step by element size
  assign incPtr = !curCfg.postInc ? curPtr :
    curPtr + (curCfg.byteMode ? `MDC_BYTE_STEP : `MDC_WORD_STEP);
  // [R8] [R9] next block start
  assign reloadPtr = (curCfg.mode == `MDC_MODE_PINGPONG && !curPing) ?
    curCfg.startB : curCfg.startA;

  ////////////////////////////////////////////////////////////////////
  // channel state, one private slot per channel

  // [R1] [R2] eight private channel slots
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < `MDC_NCH; i++) begin
        ptr_r[i] <= `MDC_PTR_RST;
        remain_r[i] <= `MDC_CNT_RST;
      end
      pend_r <= '0;
      halted_r <= '0;
      pingB_r <= '0;
      enPrev_r <= '0;
    end else begin
      enPrev_r <= enVec;
      for (int i = 0; i < `MDC_NCH; i++) begin
        if (startup[i]) begin
          ptr_r[i] <= chanCfg[i].startA;
          remain_r[i] <= chanCfg[i].blockLen;
          pingB_r[i] <= 1'b0;
          halted_r[i] <= 1'b0;
        end else if (stepNow && cur_r == `MDC_CHW'(i)) begin
          // [R20] count down, reload at end
          if (endNow) begin
            remain_r[i] <= curCfg.blockLen;
            ptr_r[i] <= reloadPtr;
            // [R9] swap buffers
            if (curCfg.mode == `MDC_MODE_PINGPONG) begin
              pingB_r[i] <= ~pingB_r[i];
            end
            // [R7] one-shot halts
            if (curCfg.mode == `MDC_MODE_ONESHOT) begin
              halted_r[i] <= 1'b1;
            end
          end else begin
            remain_r[i] <= curRemain - `MDC_LW'(1);
            ptr_r[i] <= incPtr;
          end
        end
        // [R10] new request wins over grant clear
        if (reqHit[i]) begin
          pend_r[i] <= 1'b1;
        end else if (!enVec[i] || (grant && gntIdx == `MDC_CHW'(i))) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // element sequencer

  // [R18] hardware walks the block element by element
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= MDC_ST_IDLE;
      cur_r <= '0;
      addr_r <= `MDC_PTR_RST;
    end else begin
      unique case (state_r)
        MDC_ST_IDLE: begin
          if (grant) begin
            cur_r <= gntIdx;
            addr_r <= gAddr;
            state_r <= MDC_ST_RD;
          end
        end
        MDC_ST_RD: state_r <= MDC_ST_CAP;
        MDC_ST_CAP: state_r <= MDC_ST_WB;
        MDC_ST_WB: state_r <= MDC_ST_IDLE;
        default: state_r <= MDC_ST_IDLE;
      endcase
    end
  end

  // [R14] [R17] private ram port, addresses only within dma ram
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ramReq <= '0;
      perReq <= '0;
    end else begin
      ramReq.re <= 1'b0;
      ramReq.we <= 1'b0;
      perReq.re <= 1'b0;
      perReq.we <= 1'b0;
      // [R3] read side chosen by direction
      if (grant) begin
        if (gCfg.toPeriph) begin
          ramReq.re <= 1'b1;
          ramReq.addr <= gAddr;
          ramReq.be <= `MDC_BE_ALL;
        end else begin
          perReq.re <= 1'b1;
          perReq.sel <= gCfg.reqSel;
        end
      end
      // [R3] [R4] write side, byte lanes
      if (stepNow) begin
        if (curCfg.toPeriph) begin
          perReq.we <= 1'b1;
          perReq.sel <= curCfg.reqSel;
          if (!curCfg.byteMode) begin
            perReq.wdata <= ramRdata;
          end else if (addr_r[0]) begin
            perReq.wdata <= {`MDC_BW'(0), ramRdata[`MDC_DW-1:`MDC_BW]};
          end else begin
            perReq.wdata <= {`MDC_BW'(0), ramRdata[`MDC_BW-1:0]};
          end
        end else begin
          ramReq.we <= 1'b1;
          ramReq.addr <= addr_r;
          if (curCfg.byteMode) begin
            ramReq.wdata <= {2{periphRdata[`MDC_BW-1:0]}};
            ramReq.be <= addr_r[0] ? `MDC_BE_HI : `MDC_BE_LO;
          end else begin
            ramReq.wdata <= periphRdata;
            ramReq.be <= `MDC_BE_ALL;
          end
        end
      end
    end
  end

  // [R12] [R13] one interrupt pulse per channel
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      chanIrq <= '0;
      chanBusy <= '0;
    end else begin
      chanBusy <= enVec & ~halted_r;
      if (stepNow && (curCfg.halfIrq ? halfNow : endNow)) begin
        chanIrq <= curMask;
      end else begin
        chanIrq <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstN);

  grant_lowest_a: assert property ( // [R19]
    (grant && pendable[0]) |=> (cur_r == '0) && (state_r == MDC_ST_RD))
    else $error("lowest channel not granted");
  elem_sequence_a: assert property ( // [R18]
    (state_r == MDC_ST_RD) |=> (state_r == MDC_ST_CAP) ##1
    (state_r == MDC_ST_WB) ##1 (state_r == MDC_ST_IDLE))
    else $error("element sequence broken");
  one_side_a: assert property ( // [R3]
    (state_r == MDC_ST_WB) |-> (ramReq.we != perReq.we) &&
    !ramReq.re && !perReq.re)
    else $error("write not on exactly one side");
  byte_lane_a: assert property ( // [R4]
    (stepNow && curCfg.byteMode && !curCfg.toPeriph) |=>
    $onehot(ramReq.be) && ramReq.we)
    else $error("byte write not on one lane");
  oneshot_halt_a: assert property ( // [R7]
    (stepNow && endNow && curCfg.mode == `MDC_MODE_ONESHOT) |=>
    halted_r[$past(cur_r)] ##1 !chanBusy[$past(cur_r, 2)])
    else $error("one-shot channel kept running");
  cont_reload_a: assert property ( // [R8]
    (stepNow && endNow && curCfg.mode == `MDC_MODE_CONT) |=>
    (curPtr == $past(curCfg.startA)))
    else $error("continuous start not reloaded");
  pingpong_swap_a: assert property ( // [R9]
    (stepNow && endNow && curCfg.mode == `MDC_MODE_PINGPONG) |=>
    (curPing != $past(curPing)) && (curPtr == $past(reloadPtr)))
    else $error("ping-pong buffer not swapped");
  end_irq_a: assert property ( // [R12]
    (stepNow && endNow && !curCfg.halfIrq) |=>
    (chanIrq == $past(curMask)) ##1 (chanIrq == '0))
    else $error("block end interrupt missing");
  half_irq_a: assert property ( // [R13]
    (stepNow && curCfg.halfIrq && !halfNow) |=> (chanIrq == '0))
    else $error("interrupt outside its point");
  count_down_a: assert property ( // [R20]
    (stepNow && !endNow) |=> (curRemain == $past(curRemain) - `MDC_LW'(1)))
    else $error("block counter did not decrement");
  force_req_a: assert property ( // [R10]
    (forceReq[0] && chanCfg[0].enable && !halted_r[0] && !startup[0]) |=>
    pend_r[0] || (state_r == MDC_ST_RD))
    else $error("forced request lost");

  pp_block_c: cover property (stepNow && endNow &&
    curCfg.mode == `MDC_MODE_PINGPONG);
  half_irq_c: cover property (stepNow && halfNow && curCfg.halfIrq);
  byte_move_c: cover property (stepNow && curCfg.byteMode);
  contend_c: cover property (grant && $countones(pendable) > 1);
endmodule
`default_nettype wire

// ===== rtl/mdc_regs.svh
/*
 * constants of the eight-channel dma controller: widths, codes, steps.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH
`define MDC_NCH 8
`define MDC_CHW 3
`define MDC_NIRQ 128
`define MDC_SELW 7
`define MDC_AW 11
`define MDC_DW 16
`define MDC_BW 8
`define MDC_LW 10
`define MDC_IND_W 8
`define MDC_MODE_ONESHOT 2'h0
`define MDC_MODE_CONT 2'h1
`define MDC_MODE_PINGPONG 2'h2
`define MDC_WORD_STEP 11'h002
`define MDC_BYTE_STEP 11'h001
`define MDC_PTR_RST 11'h000
`define MDC_CNT_RST 10'h000
`define MDC_BE_ALL 2'h3
`define MDC_BE_LO 2'h1
`define MDC_BE_HI 2'h2
`define MDC_IRQ_EXT0 7'h00
`define MDC_IRQ_CAP1 7'h01
`define MDC_IRQ_CMP1 7'h02
`define MDC_IRQ_CAP2 7'h05
`define MDC_IRQ_CMP2 7'h06
`define MDC_IRQ_TMR2 7'h07
`define MDC_IRQ_TMR3 7'h08
`define MDC_IRQ_SPI1 7'h0A
`define MDC_IRQ_U1RX 7'h0B
`define MDC_IRQ_U1TX 7'h0C
`define MDC_IRQ_ADC1 7'h0D
`define MDC_IRQ_ADC2 7'h15
`define MDC_IRQ_U2RX 7'h1E
`define MDC_IRQ_U2TX 7'h1F
`define MDC_IRQ_SPI2 7'h21
`define MDC_IRQ_CAN1RX 7'h22
`define MDC_IRQ_CAN2RX 7'h37
`define MDC_IRQ_CODEC 7'h3C
`define MDC_IRQ_CAN1TX 7'h46
`define MDC_IRQ_CAN2TX 7'h47
`endif

// ===== rtl/mdc_pkg.sv
/*
 * types of the eight-channel dma controller.
 * assumes mdc_regs.svh on the include path.
 */
`default_nettype none
`include "mdc_regs.svh"
package mdc_pkg;
  typedef struct packed {
    logic enable;
    logic toPeriph;
    logic byteMode;
    logic postInc;
    logic periphInd;
    logic [1:0] mode;
    logic halfIrq;
    logic [`MDC_SELW-1:0] reqSel;
    logic [`MDC_AW-1:0] startA;
    logic [`MDC_AW-1:0] startB;
    logic [`MDC_LW-1:0] blockLen;
  } mdc_chan_cfg_type;
  typedef struct packed {
    logic re;
    logic we;
    logic [1:0] be;
    logic [`MDC_AW-1:0] addr;
    logic [`MDC_DW-1:0] wdata;
  } mdc_ram_req_type;
  typedef struct packed {
    logic re;
    logic we;
    logic [`MDC_SELW-1:0] sel;
    logic [`MDC_DW-1:0] wdata;
  } mdc_per_req_type;
  typedef enum logic [3:0] {
    MDC_ST_IDLE = 4'b0001,
    MDC_ST_RD = 4'b0010,
    MDC_ST_CAP = 4'b0100,
    MDC_ST_WB = 4'b1000
  } mdc_state_type;
endpackage
`default_nettype wire

// ===== dv/mdc_far_side.sv
/*
 * far-side model of the dma engine: dual-port ram and peripheral registers.
 * assumes one-cycle read latency on both ports and the core_clk of the engine.
 */
`default_nettype none
`include "mdc_regs.svh"
module mdc_far_side import mdc_pkg::*; (
  input wire logic core_clk,
  input wire mdc_pkg::mdc_ram_req_type ramReq,
  input wire mdc_pkg::mdc_per_req_type perReq,
  output var logic [`MDC_DW-1:0] ramRdata,
  output var logic [`MDC_DW-1:0] periphRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`MDC_DW-1:0] mem [0:1023];
  logic [`MDC_DW-1:0] perLog [0:63];
  int perReads = 0;
  int perWrites = 0;
  int ramWrites = 0;
  initial begin
    ramRdata = 16'h0000;
    periphRdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // whole ram space reachable
  always @(posedge core_clk) begin
    if (ramReq.we === 1'b1) begin
      if (ramReq.be[0]) mem[ramReq.addr[10:1]][7:0] <= ramReq.wdata[7:0];
      if (ramReq.be[1]) mem[ramReq.addr[10:1]][15:8] <= ramReq.wdata[15:8];
      ramWrites <= ramWrites + 1;
    end
    // an idle port shows the inverse so a late sample never matches
    ramRdata <= (ramReq.re === 1'b1) ? mem[ramReq.addr[10:1]] : ~ramRdata;
    if (perReq.re === 1'b1) perReads <= perReads + 1;
    periphRdata <= (perReq.re === 1'b1) ? {perReads[8:0], perReq.sel} : ~periphRdata;
    if (perReq.we === 1'b1) begin
      perLog[perWrites[5:0]] <= perReq.wdata;
      perWrites <= perWrites + 1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/mdc_dma_ctrl_tb.sv
/*
 * self-checking bench of the eight-channel dma engine.
 * assumes the far-side model and the design package compiled first.
 */
`default_nettype none
`include "mdc_regs.svh"
module mdc_dma_ctrl_tb import mdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  mdc_chan_cfg_type [`MDC_NCH-1:0] chanCfg = '0;
  logic [`MDC_NCH-1:0] forceReq = '0;
  logic [`MDC_NIRQ-1:0] periphIrq = '0;
  logic [`MDC_IND_W-1:0] periphIndBits = 8'h00;
  logic [`MDC_DW-1:0] periphRdata;
  logic [`MDC_DW-1:0] ramRdata;
  mdc_ram_req_type ramReq;
  mdc_per_req_type perReq;
  logic [`MDC_NCH-1:0] chanIrq;
  logic [`MDC_NCH-1:0] chanBusy;
  int errTotal = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int irqCnt [`MDC_NCH];
  int irqWr [`MDC_NCH];
  logic [`MDC_SELW-1:0] selLog [$];
  // last entry is an unlisted code that must not trigger
  logic [`MDC_SELW-1:0] codes [21] = '{`MDC_IRQ_EXT0, `MDC_IRQ_CAP1, `MDC_IRQ_CMP1,
    `MDC_IRQ_CAP2, `MDC_IRQ_CMP2, `MDC_IRQ_TMR2, `MDC_IRQ_TMR3, `MDC_IRQ_SPI1,
    `MDC_IRQ_U1RX, `MDC_IRQ_U1TX, `MDC_IRQ_ADC1, `MDC_IRQ_ADC2, `MDC_IRQ_U2RX,
    `MDC_IRQ_U2TX, `MDC_IRQ_SPI2, `MDC_IRQ_CAN1RX, `MDC_IRQ_CAN2RX, `MDC_IRQ_CODEC,
    `MDC_IRQ_CAN1TX, `MDC_IRQ_CAN2TX, 7'h03};

  always #2.5 core_clk = ~core_clk;

  mdc_dma_ctrl u_mdc_dma_ctrl (.core_clk(core_clk), .reset_n(reset_n), .chanCfg(chanCfg),
    .forceReq(forceReq), .periphIrq(periphIrq), .periphIndBits(periphIndBits),
    .periphRdata(periphRdata), .ramRdata(ramRdata), .ramReq(ramReq), .perReq(perReq),
    .chanIrq(chanIrq), .chanBusy(chanBusy));
  mdc_far_side u_mdc_far_side (.core_clk(core_clk), .ramReq(ramReq), .perReq(perReq),
    .ramRdata(ramRdata), .periphRdata(periphRdata));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles++;
    for (int c = 0; c < `MDC_NCH; c++) begin
      if (chanIrq[c] === 1'b1) begin
        irqCnt[c] <= irqCnt[c] + 1;
        irqWr[c] <= u_mdc_far_side.ramWrites;
      end
    end
    if (perReq.re === 1'b1) selLog.push_back(perReq.sel);
    if (cycles == 20000) begin
      errTotal++;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // f = {toPeriph, byteMode, postInc, periphInd}
  function automatic mdc_chan_cfg_type mk(input logic [3:0] f, input logic [1:0] md,
      input logic [6:0] sel, input logic [10:0] a, input logic [10:0] b,
      input logic [9:0] len);
    mk = '{1'b0, f[3], f[2], f[1], f[0], md, 1'b0, sel, a, b, len};
  endfunction

  // enable rises a cycle after the fields settle so the start load sees them
  task automatic start(input int ch, input mdc_chan_cfg_type c);
    @(negedge core_clk);
    chanCfg[ch] = c;
    @(negedge core_clk);
    chanCfg[ch].enable = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic kick(input logic [7:0] m, input int code, input int n);
    repeat (n) begin
      @(negedge core_clk);
      forceReq = m;
      if (code >= 0) periphIrq[code] = 1'b1;
      @(negedge core_clk);
      forceReq = '0;
      periphIrq = '0;
      repeat (11) @(negedge core_clk);
    end
    chanCfg = '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // all buffers below lie inside the ram model
  task automatic t_oneshot();
    int b;
    int w;
    b = u_mdc_far_side.perReads;
    w = u_mdc_far_side.ramWrites;
    start(0, mk(4'b0010, `MDC_MODE_ONESHOT, `MDC_IRQ_ADC1, 11'h100, 11'h000, 10'h002));
    // one call keeps the channel enabled; the fourth request meets the halt
    kick(8'h01, 13, 4);
    for (int i = 0; i < 3; i++)
      chk("word", {9'(b + i), `MDC_IRQ_ADC1}, u_mdc_far_side.mem[10'h080 + i]);
    chk("oneshot writes", 16'h0003, 16'(u_mdc_far_side.ramWrites - w));
    chk("end irq", 16'h0001, 16'(irqCnt[0]));
    chk("halted busy", 16'h0000, {15'h0000, chanBusy[0]});
  endtask

  task automatic t_byte_cont();
    int p;
    p = u_mdc_far_side.perWrites;
    u_mdc_far_side.mem[10'h100] = 16'h2211;
    u_mdc_far_side.mem[10'h101] = 16'h4433;
    start(1, mk(4'b1110, `MDC_MODE_CONT, `MDC_IRQ_U1TX, 11'h201, 11'h000, 10'h001));
    kick(8'h02, -1, 4);
    for (int i = 0; i < 4; i++)
      chk("byte out", {8'h00, i[0] ? 8'h33 : 8'h22},
          {8'h00, u_mdc_far_side.perLog[6'(p + i)][7:0]});
    chk("cont irq", 16'h0002, 16'(irqCnt[1]));
  endtask

  task automatic t_pingpong();
    int b;
    b = u_mdc_far_side.perReads;
    start(2, mk(4'b0010, `MDC_MODE_PINGPONG, `MDC_IRQ_SPI1, 11'h300, 11'h380, 10'h000));
    kick(8'h04, -1, 3);
    chk("ping", {9'(b + 2), `MDC_IRQ_SPI1}, u_mdc_far_side.mem[10'h180]);
    chk("pong", {9'(b + 1), `MDC_IRQ_SPI1}, u_mdc_far_side.mem[10'h1C0]);
  endtask

  task automatic t_half();
    int w;
    mdc_chan_cfg_type c;
    w = u_mdc_far_side.ramWrites;
    c = mk(4'b0010, `MDC_MODE_CONT, `MDC_IRQ_U1RX, 11'h400, 11'h000, 10'h003);
    c.halfIrq = 1'b1;
    start(3, c);
    kick(8'h08, -1, 4);
    chk("half count", 16'h0001, 16'(irqCnt[3]));
    chk("half point", 16'(w + 2), 16'(irqWr[3]));
  endtask

  task automatic t_priority();
    start(4, mk(4'b0010, `MDC_MODE_ONESHOT, `MDC_IRQ_CAP1, 11'h500, 11'h000, 10'h000));
    start(6, mk(4'b0010, `MDC_MODE_ONESHOT, `MDC_IRQ_CMP1, 11'h540, 11'h000, 10'h000));
    selLog.delete();
    kick(8'h50, -1, 1);
    chk("first grant", {9'h000, `MDC_IRQ_CAP1}, {9'h000, selLog[0]});
    chk("second grant", {9'h000, `MDC_IRQ_CMP1}, {9'h000, selLog[1]});
    chk("own irqs", 16'h0101, {irqCnt[4][7:0], irqCnt[6][7:0]});
  endtask

  task automatic t_indirect();
    int b;
    b = u_mdc_far_side.perReads;
    start(5, mk(4'b0011, `MDC_MODE_ONESHOT, `MDC_IRQ_CAN1RX, 11'h600, 11'h000, 10'h000));
    periphIndBits = 8'h5A;
    kick(8'h20, -1, 1);
    chk("indirect", {9'(b), `MDC_IRQ_CAN1RX}, u_mdc_far_side.mem[10'h35A]);
  endtask

  task automatic t_byte_in();
    int b;
    logic [15:0] d0;
    logic [15:0] d1;
    b = u_mdc_far_side.perReads;
    u_mdc_far_side.mem[10'h380] = 16'h00C3;
    u_mdc_far_side.mem[10'h381] = 16'h3C00;
    start(6, mk(4'b0110, `MDC_MODE_CONT, `MDC_IRQ_U2RX, 11'h701, 11'h000, 10'h001));
    kick(8'h40, -1, 2);
    d0 = {9'(b), `MDC_IRQ_U2RX};
    d1 = {9'(b + 1), `MDC_IRQ_U2RX};
    chk("byte in odd", {d0[7:0], 8'hC3}, u_mdc_far_side.mem[10'h380]);
    chk("byte in even", {8'h3C, d1[7:0]}, u_mdc_far_side.mem[10'h381]);
  endtask

  task automatic t_codes();
    int b;
    for (int i = 0; i < 21; i++) begin
      start(7, mk(4'b0000, `MDC_MODE_CONT, codes[i], 11'h7F0, 11'h000, 10'h000));
      b = u_mdc_far_side.perReads;
      kick(8'h00, int'(codes[i]), 1);
      chk("code trigger", (i < 20) ? 16'h0001 : 16'h0000,
          16'(u_mdc_far_side.perReads - b));
    end
  endtask

  initial begin
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_oneshot();
    t_byte_cont();
    t_pingpong();
    t_half();
    t_priority();
    t_indirect();
    t_byte_in();
    t_codes();
    reportAndStop();
  end
endmodule
`default_nettype wire
